/* File: dv/seq_master.sv */
// Bus master standing in for the instruction sequencer
`timescale 1ns/1ps
module seq_master
  import vec_alu_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  logic [2:0] sz   = HSIZE_WORD;  // Bench narrows it to try refused writes
  logic       hung = 1'b0;
  // Idle bus from time zero; same assignment kind as the transfer task
  initial begin
    hsel   <= 1'b0;
    haddr  <= 32'h0;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize  <= HSIZE_WORD;
    hwdata <= 32'h0;
  end
  // Bounded wait for ready at a rising edge; a stuck slave flags a hang
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (!hready && n < 64) begin
      @(posedge sys_clk);
      n++;
    end
    if (!hready) hung = 1'b1;
  endtask : wait_ready
  // One single transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= sz;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : xfer
  // Command issue; dependent ops never go to z or w
  task automatic issue(input logic [7:0] op, input logic three, input logic [2:0] ch,
                       input logic ge);
    cmd_t        c;
    logic [31:0] q;
    c = '0;
    c.opcode_field = op;
    c.threeSrc = three;
    c.chan = ch;
    c.groupEnd = ge;
    if (!three && op inside {OP2_DEPENDENT_MAD, OP2_DEP_MAD_STRICT} && ch inside {CH_Z, CH_W})
      c.chan = CH_X;
    xfer(1'b1, OFF_CMD, c, q);
  endtask : issue
endmodule : seq_master

/* File: dv/vector_alu_mul_pred_chk.sv */
// Bus timing and predicate checks for the vector ALU slot
`timescale 1ns/1ps
module vector_alu_mul_pred_chk
  import vec_alu_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        predicateSkip
);
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic [31:0] s0;
  logic [31:0] s1;
  cmd_t        cmd;
  logic        takenR;
  logic        takenW;
  logic        cmdNow;
  logic        posPair;
  // Address phase decode and the command in its data phase
  assign takenR  = hsel && htrans[1] && hready && !hwrite;
  assign takenW  = hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD;
  assign cmd     = hwdata;
  assign cmdNow  = wrPend && wrAddr == OFF_CMD && !cmd.threeSrc && cmd.chan < 3'h5;
  // Positive normals order like their bit patterns, so no float compare needed
  assign posPair = !s0[31] && !s1[31] && |s0[30:23] && |s1[30:23];
  // Shadow of the sources so predicate checks know their operands
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      s0     <= 32'h0;
      s1     <= 32'h0;
    end else if (hready) begin
      wrPend <= takenW;
      wrAddr <= haddr[7:0];
      if (wrPend && wrAddr == OFF_SRC0) s0 <= hwdata;
      if (wrPend && wrAddr == OFF_SRC1) s1 <= hwdata;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_clear_skip: assert property (
    cmdNow && cmd.opcode_field == OP2_PRED_CLEAR |=> predicateSkip == PRED_SKIP)
    else $error("predicate clear left execute");
  a_invert_exec: assert property (
    cmdNow && cmd.opcode_field == OP2_PRED_INVERT && s0 == FP_ONE |=> !predicateSkip)
    else $error("invert of one did not execute");
  a_invert_skip: assert property (
    cmdNow && cmd.opcode_field == OP2_PRED_INVERT && s0 != FP_ONE |=> predicateSkip)
    else $error("invert of other value did not skip");
  a_pop_order: assert property (
    cmdNow && cmd.opcode_field == OP2_PRED_POP && posPair |=> predicateSkip == (s0 > s1))
    else $error("pop predicate wrong for operand order");
  a_pred_holds: assert property (
    !(wrPend && wrAddr == OFF_CMD) |=> $stable(predicateSkip))
    else $error("predicate moved without a command");
  a_read_wait: assert property (takenR |=> !hreadyout ##1 hreadyout)
    else $error("read did not take one wait state");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write was stalled");
  a_rdata_holds: assert property (!takenR |=> ##1 $stable(hrdata))
    else $error("read data changed without a read");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response other than okay");
endmodule : vector_alu_mul_pred_chk

bind vector_alu_mul_pred_ops vector_alu_mul_pred_chk vector_alu_mul_pred_chk_inst (
  .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .predicateSkip(predicateSkip));

/* File: dv/vector_alu_mul_pred_ops_tb_top.sv */
// Self-checking bench for the vector ALU slot
`timescale 1ns/1ps
module vector_alu_mul_pred_ops_tb_top;
  import vec_alu_pkg::*;
  typedef struct packed {
    logic [7:0]  op;
    logic        three;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] res;
    logic        isPred;
    logic        pred;
  } row_t;
  logic        sys_clk = 1'b0;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        predicateSkip;
  int          errorCnt;
  int          nTests;
  logic        expPred;
  logic [31:0] q;
  // Ordinary cases: opcode, format, sources, result, predicate
  row_t rows [18] = '{
    '{OP3_MAD_TIMES_TWO, 1'b1, FP_ONE, 32'h40000000, FP_ONE, 32'h40c00000, 1'b0, 1'b0},
    '{OP3_MAD_TIMES_FOUR, 1'b1, FP_ONE, 32'h40000000, FP_ONE, 32'h41400000, 1'b0, 1'b0},
    '{OP3_NARROW_UNS_MAD, 1'b1, 32'hff000003, 32'hab000005, 32'hffffffff, 32'h0000000e,
      1'b0, 1'b0},
    '{OP2_PRED_CLEAR, 1'b0, FP_ONE, FP_ONE, 32'h0, FP_MAX, 1'b1, 1'b1},
    '{OP2_SIGNED_MUL_UP, 1'b0, 32'hffffffff, 32'h00000002, 32'h0, 32'hffffffff, 1'b0, 1'b0},
    '{OP2_UNSIGNED_MUL_UP, 1'b0, 32'hffffffff, 32'h00000002, 32'h0, 32'h00000001, 1'b0, 1'b0},
    '{OP2_NARROW_MUL_UP, 1'b0, 32'hff800000, 32'hff800000, 32'h0, 32'h00004000, 1'b0, 1'b0},
    '{OP2_SIGNED_MUL_LO, 1'b0, 32'hffffffff, 32'h00000003, 32'h0, 32'hfffffffd, 1'b0, 1'b0},
    '{OP2_UNSIGNED_MUL_LO, 1'b0, 32'h80000001, 32'h00000003, 32'h0, 32'h80000003, 1'b0, 1'b0},
    '{OP2_BIT_INVERT, 1'b0, 32'h0f0f00ff, 32'h0, 32'h0, 32'hf0f0ff00, 1'b0, 1'b0},
    '{OP2_BIT_OR, 1'b0, 32'h0f000f00, 32'h00f000f0, 32'h0, 32'h0ff00ff0, 1'b0, 1'b0},
    '{OP2_NIBBLE_TO_FLOAT, 1'b0, 32'h00000008, 32'h0, 32'h0, 32'hbf000000, 1'b0, 1'b0},
    '{OP2_PRED_INVERT, 1'b0, FP_ONE, 32'h0, 32'h0, 32'h0, 1'b1, 1'b0},
    '{OP2_PRED_INVERT, 1'b0, 32'h0, 32'h0, 32'h0, FP_ONE, 1'b1, 1'b1},
    '{OP2_PRED_INVERT, 1'b0, 32'h40400000, 32'h0, 32'h0, 32'h40400000, 1'b1, 1'b1},
    '{OP2_PRED_POP, 1'b0, FP_ONE, 32'h40000000, 32'h0, 32'h0, 1'b1, 1'b0},
    '{OP2_PRED_POP, 1'b0, 32'h40000000, 32'h40000000, 32'h0, 32'h0, 1'b1, 1'b0},
    '{OP2_PRED_POP, 1'b0, 32'h40400000, FP_ONE, 32'h0, 32'h40000000, 1'b1, 1'b1}};

  vector_alu_mul_pred_ops vector_alu_mul_pred_ops_inst (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .predicateSkip(predicateSkip));
  seq_master seq_master_inst (
    .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // Free-running clock, 8 ns period
  always #4 sys_clk = ~sys_clk;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    seq_master_inst.xfer(1'b1, a, d, t);
  endtask : wr
  // Reads also catch a hung bus from any earlier transfer
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    seq_master_inst.xfer(1'b0, a, 32'h0, d);
    if (seq_master_inst.hung) begin
      errorCnt++;
      final_report();
    end
  endtask : rd

  // Main sequence: reset, table, then the awkward cases
  initial begin
    resetn <= 1'b0;
    errorCnt = 0;
    nTests = 0;
    expPred = PRED_EXECUTE;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(OFF_STATUS, q);
    chk(q, 32'h0);
    foreach (rows[i]) begin
      wr(OFF_SRC0, rows[i].a);
      wr(OFF_SRC1, rows[i].b);
      wr(OFF_SRC2, rows[i].c);
      seq_master_inst.issue(rows[i].op, rows[i].three, CH_X, 1'b0);
      if (rows[i].isPred) expPred = rows[i].pred;
      rd(OFF_RESULT, q);
      chk(q, rows[i].res);
      chk({31'h0, predicateSkip}, {31'h0, expPred});
    end
    // Dependent ops: w feeds y, z feeds x
    wr(OFF_SRC0, FP_ONE);
    wr(OFF_SRC1, 32'h0);
    seq_master_inst.issue(OP2_BIT_OR, 1'b0, CH_W, 1'b0);
    wr(OFF_SRC0, 32'h40000000);
    seq_master_inst.issue(OP2_BIT_OR, 1'b0, CH_Z, 1'b0);
    wr(OFF_SRC1, 32'h40400000);
    seq_master_inst.issue(OP2_DEPENDENT_MAD, 1'b0, CH_Y, 1'b0);
    rd(8'h24, q);
    chk(q, 32'h40e00000);
    wr(OFF_SRC0, 32'h0);
    wr(OFF_SRC1, 32'h7f800000);
    seq_master_inst.issue(OP2_DEP_MAD_STRICT, 1'b0, CH_X, 1'b0);
    rd(OFF_RESULT, q);
    chk(q, FP_NAN);
    seq_master_inst.issue(OP2_DEPENDENT_MAD, 1'b0, CH_X, 1'b0);
    rd(OFF_RESULT, q);
    chk(q, 32'h40000000);
    // Idle slot keeps the result but drops its previous value
    seq_master_inst.issue(OP2_IDLE_SLOT, 1'b0, CH_W, 1'b0);
    rd(OFF_RESULT, q);
    chk(q, 32'h40000000);
    rd(OFF_STATUS, q);
    chk(q & 32'h0000003e, 32'h0000000e);
    // Fresh group holding only y; the rest lose their previous values
    seq_master_inst.issue(OP2_IDLE_SLOT, 1'b0, 3'h5, 1'b1);
    seq_master_inst.issue(OP2_BIT_OR, 1'b0, CH_Y, 1'b1);
    rd(OFF_STATUS, q);
    chk(q & 32'h00001f3e, 32'h00000004);
    // Refused writes and unmapped reads
    seq_master_inst.sz = 3'h0;
    wr(OFF_SRC0, 32'h12345678);
    seq_master_inst.sz = HSIZE_WORD;
    wr(OFF_RESULT, 32'h12345678);
    rd(OFF_SRC0, q);
    chk(q, 32'h0);
    rd(OFF_RESULT, q);
    chk(q, 32'h7f800000);
    rd(8'h18, q);
    chk(q, 32'h0);
    rd(8'h34, q);
    chk(q, 32'h0);
    // Reset in mid-run clears a skip predicate
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, predicateSkip}, 32'h0);
    rd(OFF_STATUS, q);
    chk(q, 32'h0);
    final_report();
  end
endmodule : vector_alu_mul_pred_ops_tb_top

/* File: rtl/vec_alu_pkg.sv */
// Shared constants and types for the vector ALU multiply/predicate slot
package vec_alu_pkg;

  // Register byte offsets on the AHB-Lite port
  localparam logic [7:0] OFF_SRC0      = 8'h00;
  localparam logic [7:0] OFF_SRC1      = 8'h04;
  localparam logic [7:0] OFF_SRC2      = 8'h08;
  localparam logic [7:0] OFF_CMD       = 8'h0c;
  localparam logic [7:0] OFF_RESULT    = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  localparam logic [2:0] PREV_PAGE     = 3'h1;  // 0x20..0x3f holds previous results
  localparam int         DEC_W         = 8;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Status register layout
  localparam int ST_PRED      = 0;
  localparam int ST_VALID_LSB = 1;
  localparam int ST_ISSUE_LSB = 8;

  // Channels: x, y, z, w and the transcendental slot
  localparam int         NUM_CH = 5;
  localparam logic [2:0] CH_X   = 3'h0;
  localparam logic [2:0] CH_Y   = 3'h1;
  localparam logic [2:0] CH_Z   = 3'h2;
  localparam logic [2:0] CH_W   = 3'h3;

  // Three-source opcodes
  localparam logic [7:0] OP3_MAD_TIMES_TWO   = 8'h15;
  localparam logic [7:0] OP3_MAD_TIMES_FOUR  = 8'h16;
  localparam logic [7:0] OP3_NARROW_UNS_MAD  = 8'h10;
  // Two-source opcodes
  localparam logic [7:0] OP2_DEPENDENT_MAD   = 8'hd4;
  localparam logic [7:0] OP2_DEP_MAD_STRICT  = 8'hd5;
  localparam logic [7:0] OP2_SIGNED_MUL_UP   = 8'h90;
  localparam logic [7:0] OP2_UNSIGNED_MUL_UP = 8'h92;
  localparam logic [7:0] OP2_NARROW_MUL_UP   = 8'hb2;
  localparam logic [7:0] OP2_SIGNED_MUL_LO   = 8'h8f;
  localparam logic [7:0] OP2_UNSIGNED_MUL_LO = 8'h91;
  localparam logic [7:0] OP2_IDLE_SLOT       = 8'h1a;
  localparam logic [7:0] OP2_BIT_INVERT      = 8'h33;
  localparam logic [7:0] OP2_NIBBLE_TO_FLOAT = 8'hb4;
  localparam logic [7:0] OP2_BIT_OR          = 8'h31;
  localparam logic [7:0] OP2_PRED_CLEAR      = 8'h26;
  localparam logic [7:0] OP2_PRED_INVERT     = 8'h24;
  localparam logic [7:0] OP2_PRED_POP        = 8'h25;

  // Float constants and field limits
  localparam logic [31:0] FP_ONE     = 32'h3f800000;
  localparam logic [31:0] FP_MAX     = 32'h7f7fffff;
  localparam logic [31:0] FP_NAN     = 32'h7fc00000;
  localparam logic [30:0] FP_INF_MAG = 31'h7f800000;
  localparam logic [7:0]  EXP_ALL1   = 8'hff;
  localparam int          EXP_BIAS   = 127;
  localparam int          EXP_TOP    = 255;
  localparam int          PROD_LEAD  = 46;   // Lead bit of a normal product
  localparam int          SUM_MSB    = 48;
  localparam int          NIB_SHIFT  = 4;    // Nibble is divided by sixteen
  localparam int          SCALE_TWO  = 1;
  localparam int          SCALE_FOUR = 2;

  // Predicate states
  localparam logic PRED_EXECUTE = 1'b0;
  localparam logic PRED_SKIP    = 1'b1;

  // Command word written to OFF_CMD
  typedef struct packed {
    logic [18:0] rsvd;
    logic        groupEnd;
    logic        threeSrc;
    logic [2:0]  chan;
    logic [7:0]  opcode_field;
  } cmd_t;

  // Captured AHB address phase
  typedef struct packed {
    logic             sel;
    logic             write;
    logic             word;
    logic [DEC_W-1:0] addr;
  } ahb_req_t;

endpackage : vec_alu_pkg

/* File: rtl/vector_alu_mul_pred_ops.sv */
// Vector ALU slot: multiply-add, integer multiply, logic and predicate ops
//
// Functional notes
// - Multiply-add times two: (src0*src1+src2)*2, three-source format.
// - Multiply-add times four: (src0*src1+src2)*4, three-source format.
// - Dependent mad adds paired channel result; y pairs with w, x with z.
// - Strict-zero dependent mad follows IEEE for zero times anything.
// - Narrow mad uses low 24 bits of src0/src1, adds full src2.
// - Signed upper multiply returns high 32 bits of signed product.
// - Unsigned upper multiply returns high 32 bits of unsigned product.
// - Narrow upper multiply returns product bits 47..32, zero extended.
// - Signed lower multiply returns low 32 bits of product.
// - Unsigned lower multiply returns low 32 bits of product.
// - Idle slot writes nothing and invalidates its previous result.
// - At group end unissued channels invalidate their previous results.
// - Bitwise invert writes one's complement of src0.
// - Nibble to float: signed 4-bit src0 divided by sixteen.
// - Bitwise OR writes src0 | src1.
// - Predicate clear writes largest float and sets skip.
// - Predicate invert: 1.0 gives 0/execute, else skip with 1.0 or src0.
// - Predicate pop: src0<=src1 gives 0/execute, else difference/skip.
// - Predicate pop decodes from two-source opcode thirty-seven.
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module vector_alu_mul_pred_ops
  import vec_alu_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             predicateSkip
);

  // Operand classification, shared by the float paths
  function automatic logic isZero(input logic [31:0] x);
    isZero = (x[30:23] == 8'h00);  // Denormals flush to zero
  endfunction : isZero

  function automatic logic isInf(input logic [31:0] x);
    isInf = (x[30:23] == EXP_ALL1) && (x[22:0] == 23'h000000);
  endfunction : isInf

  function automatic logic isNan(input logic [31:0] x);
    isNan = (x[30:23] == EXP_ALL1) && (x[22:0] != 23'h000000);
  endfunction : isNan

  // Fused a*b+c, truncating; strict selects IEEE zero handling
  function automatic logic [31:0] fmad(input logic [31:0] a, input logic [31:0] b,
                                       input logic [31:0] c, input logic strict);
    logic        ps, bs, ss, rs, pz, pn, pi;
    logic [47:0] pm;
    logic [48:0] big, sml, s, t;
    int          pe, ce, eb, d, p, re;
    ps = a[31] ^ b[31];
    pz = isZero(a) | isZero(b);
    pn = strict ? (isNan(a) | isNan(b) | (pz & (isInf(a) | isInf(b))))
                : (!pz & (isNan(a) | isNan(b)));
    pi = !pz & !pn & (isInf(a) | isInf(b));
    fmad = 32'h00000000;
    pm = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    pe = int'(a[30:23]) + int'(b[30:23]) - EXP_BIAS;
    ce = isZero(c) ? pe : int'(c[30:23]);
    if (pn | isNan(c)) begin
      fmad = FP_NAN;
    end else if (pi & isInf(c) & (ps != c[31])) begin
      fmad = FP_NAN;
    end else if (pi) begin
      fmad = {ps, FP_INF_MAG};
    end else if (isInf(c)) begin
      fmad = c;
    end else if (pz) begin
      fmad = isZero(c) ? {ps & c[31], 31'h00000000} : c;
    end else begin
      // Align the smaller-exponent term; bits shifted out are lost
      if (pe >= ce) begin
        big = {1'b0, pm};
        sml = isZero(c) ? 49'h0 : {3'b001, c[22:0], 23'h000000};
        eb  = pe;
        bs  = ps;
        ss  = c[31];
        d   = pe - ce;
      end else begin
        big = {3'b001, c[22:0], 23'h000000};
        sml = {1'b0, pm};
        eb  = ce;
        bs  = c[31];
        ss  = ps;
        d   = ce - pe;
      end
      sml = (d > SUM_MSB) ? 49'h0 : (sml >> d);
      if (bs == ss) begin
        s  = big + sml;
        rs = bs;
      end else if (big >= sml) begin
        s  = big - sml;
        rs = bs;
      end else begin
        s  = sml - big;
        rs = ss;
      end
      p = 0;
      for (int i = 0; i <= SUM_MSB; i++) begin
        if (s[i]) p = i;
      end
      re = eb + p - PROD_LEAD;
      t  = s << (SUM_MSB - p);
      if (s == 49'h0) fmad = 32'h00000000;
      else if (re >= EXP_TOP) fmad = {rs, FP_INF_MAG};
      else if (re <= 0) fmad = {rs, 31'h00000000};
      else fmad = {rs, re[7:0], t[47:25]};
    end
  endfunction : fmad

  // Post-scale by a power of two; zero, inf and NaN pass unchanged
  function automatic logic [31:0] fscale(input logic [31:0] x, input int k);
    int e;
    e = int'(x[30:23]) + k;
    if (isZero(x) | (x[30:23] == EXP_ALL1)) fscale = x;
    else if (e >= EXP_TOP) fscale = {x[31], FP_INF_MAG};
    else fscale = {x[31], e[7:0], x[22:0]};
  endfunction : fscale

  // Float a <= b; NaN compares false, signed zeros are equal
  function automatic logic fle(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] ka, kb;
    ka = a[31] ? ~a : (a | 32'h80000000);
    kb = b[31] ? ~b : (b | 32'h80000000);
    if (isNan(a) | isNan(b)) fle = 1'b0;
    else if (isZero(a) & isZero(b)) fle = 1'b1;
    else fle = (ka <= kb);
  endfunction : fle

  // Signed nibble over sixteen, exact in single precision
  function automatic logic [31:0] nibbleToFloat(input logic [3:0] v);
    logic [3:0]  mag;
    logic [22:0] fr;
    int          p, e;
    mag = v[3] ? 4'(-v) : v;
    p = 0;
    for (int i = 0; i < NIB_SHIFT; i++) begin
      if (mag[i]) p = i;
    end
    fr = 23'(mag) << (23 - p);   // Lead bit drops off the top
    e  = EXP_BIAS - NIB_SHIFT + p;
    nibbleToFloat = (mag == 4'h0) ? 32'h00000000 : {v[3], e[7:0], fr};
  endfunction : nibbleToFloat

  // Channel whose result a dependent mad consumes
  function automatic logic [2:0] pairOf(input logic [2:0] ch);
    case (ch)
      CH_Y:    pairOf = CH_W;
      CH_X:    pairOf = CH_Z;
      default: pairOf = ch;
    endcase
  endfunction : pairOf

  logic [1:0]  rstSync;
  logic        rstn;
  ahb_req_t    req;
  logic [31:0] src0, src1, src2, result;
  cmd_t        lastCmd;
  logic [31:0] prevResult [NUM_CH];
  logic [NUM_CH-1:0] prevValid, issued;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) rstSync <= 2'b00;
    else rstSync <= {rstSync[0], 1'b1};
  end
  assign rstn = rstSync[1];

  // Address phase capture; only NONSEQ/SEQ with hready are taken
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      req <= '0;
    end else if (hready) begin
      req.sel   <= hsel & htrans[1];
      req.write <= hwrite;
      req.word  <= (hsize == HSIZE_WORD);
      req.addr  <= haddr[DEC_W-1:0];
    end
  end

  // Command is executed in its own write data phase so a following read sees it
  cmd_t        cmdIn;
  logic        issue;
  logic [31:0] prevIn, res;
  logic [63:0] mulS, mulU;
  logic [47:0] mulN;
  logic        wrDst, hasPred, predVal;

  assign cmdIn  = cmd_t'(hwdata);
  assign issue  = req.sel & req.write & req.word & (req.addr == OFF_CMD);
  assign prevIn = (pairOf(cmdIn.chan) < NUM_CH) ? prevResult[pairOf(cmdIn.chan)] : 32'h00000000;
  assign mulS   = {{32{src0[31]}}, src0} * {{32{src1[31]}}, src1};
  assign mulU   = {32'h00000000, src0} * {32'h00000000, src1};
  assign mulN   = 48'(src0[23:0]) * 48'(src1[23:0]);

  // Opcode decode and datapath; long path, but one result per issue
  always_comb begin
    wrDst   = 1'b1;
    hasPred = 1'b0;
    predVal = PRED_EXECUTE;
    res     = 32'h00000000;
    if (cmdIn.threeSrc) begin
      case (cmdIn.opcode_field)
        OP3_MAD_TIMES_TWO:  res = fscale(fmad(src0, src1, src2, 1'b0), SCALE_TWO);
        OP3_MAD_TIMES_FOUR: res = fscale(fmad(src0, src1, src2, 1'b0), SCALE_FOUR);
        OP3_NARROW_UNS_MAD: res = mulN[31:0] + src2;
        default:            wrDst = 1'b0;
      endcase
    end else begin
      case (cmdIn.opcode_field)
        OP2_DEPENDENT_MAD:   res = fmad(src0, src1, prevIn, 1'b0);
        OP2_DEP_MAD_STRICT:  res = fmad(src0, src1, prevIn, 1'b1);
        OP2_SIGNED_MUL_UP:   res = mulS[63:32];
        OP2_UNSIGNED_MUL_UP: res = mulU[63:32];
        OP2_NARROW_MUL_UP:   res = {16'h0000, mulN[47:32]};
        OP2_SIGNED_MUL_LO:   res = mulS[31:0];
        OP2_UNSIGNED_MUL_LO: res = mulU[31:0];
        OP2_BIT_INVERT:      res = ~src0;
        OP2_NIBBLE_TO_FLOAT: res = nibbleToFloat(src0[3:0]);
        OP2_BIT_OR:          res = src0 | src1;
        OP2_PRED_CLEAR: begin
          res     = FP_MAX;
          hasPred = 1'b1;
          predVal = PRED_SKIP;
        end
        OP2_PRED_INVERT: begin
          hasPred = 1'b1;
          if (src0 == FP_ONE) begin
            res     = 32'h00000000;
            predVal = PRED_EXECUTE;
          end else begin
            res     = isZero(src0) ? FP_ONE : src0;
            predVal = PRED_SKIP;
          end
        end
        OP2_PRED_POP: begin
          hasPred = 1'b1;
          if (fle(src0, src1)) begin
            res     = 32'h00000000;
            predVal = PRED_EXECUTE;
          end else begin
            res     = fmad(src0, FP_ONE, {~src1[31], src1[30:0]}, 1'b1);
            predVal = PRED_SKIP;
          end
        end
        default: wrDst = 1'b0;
      endcase
    end
  end

  // Operand registers written by the sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      src0    <= 32'h00000000;
      src1    <= 32'h00000000;
      src2    <= 32'h00000000;
      lastCmd <= '0;
    end else if (req.sel & req.write & req.word) begin
      case (req.addr)
        OFF_SRC0: src0    <= hwdata;
        OFF_SRC1: src1    <= hwdata;
        OFF_SRC2: src2    <= hwdata;
        OFF_CMD:  lastCmd <= cmdIn;
        default:  ;
      endcase
    end
  end

  // Destination result; idle slots leave it as it was
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) result <= 32'h00000000;
    else if (issue & wrDst) result <= res;
  end

  // Registered predicate seen by later predicated instructions
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) predicateSkip <= PRED_EXECUTE;
    else if (issue & hasPred) predicateSkip <= predVal;
  end

  // Previous-result channels, validity and per-group issue tracking
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prevValid <= '0;
      issued    <= '0;
      for (int i = 0; i < NUM_CH; i++) prevResult[i] <= 32'h00000000;
    end else if (issue) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (cmdIn.chan == 3'(i)) begin
          if (wrDst) prevResult[i] <= res;
          prevValid[i] <= wrDst;
          if (cmdIn.groupEnd) issued[i] <= 1'b0;
          else issued[i] <= 1'b1;
        end else if (cmdIn.groupEnd) begin
          if (!issued[i]) prevValid[i] <= 1'b0;
          issued[i] <= 1'b0;
        end
      end
    end
  end

  // Reads take one wait state so hrdata can come from a flop
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
    end else if (hreadyout) begin
      hreadyout <= !(hready & hsel & htrans[1] & !hwrite);
    end else begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      if (req.addr[DEC_W-1:5] == PREV_PAGE) begin
        if (int'(req.addr[4:2]) < NUM_CH) hrdata <= prevResult[req.addr[4:2]];
      end else begin
        case (req.addr)
          OFF_SRC0:   hrdata <= src0;
          OFF_SRC1:   hrdata <= src1;
          OFF_SRC2:   hrdata <= src2;
          OFF_CMD:    hrdata <= lastCmd;
          OFF_RESULT: hrdata <= result;
          OFF_STATUS: begin
            hrdata[ST_PRED]                           <= predicateSkip;
            hrdata[ST_VALID_LSB +: NUM_CH]            <= prevValid;
            hrdata[ST_ISSUE_LSB +: NUM_CH]            <= issued;
          end
          default:    ;  // Unmapped reads return zero
        endcase
      end
    end
  end

  // Every transfer answers OKAY
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) hresp <= 1'b0;
    else hresp <= 1'b0;
  end

endmodule : vector_alu_mul_pred_ops
